// ==== hdl/cpsr_defines.svh ====
`ifndef CPSR_DEFINES_SVH
`define CPSR_DEFINES_SVH

// Clock
`define CPSR_CLK_MHZ 50
`define CPSR_CLK_HZ (`CPSR_CLK_MHZ * 1000000)

// Word layout
`define CPSR_WORD_BITS 24
`define CPSR_LEVELS 256

// Times in their own units
`define CPSR_ONE_THRESH_NS 600
`define CPSR_ZERO_OUT_NS 300
`define CPSR_ONE_OUT_NS 900
`define CPSR_IDLE_RESET_US 300
`define CPSR_REFRESH_HZ 2000

// Derived cycle counts
`define CPSR_THRESH_CYC ((`CPSR_ONE_THRESH_NS * `CPSR_CLK_MHZ) / 1000)
`define CPSR_ZERO_OUT_CYC ((`CPSR_ZERO_OUT_NS * `CPSR_CLK_MHZ + 999) / 1000)
`define CPSR_ONE_OUT_CYC ((`CPSR_ONE_OUT_NS * `CPSR_CLK_MHZ + 999) / 1000)
`define CPSR_IDLE_RESET_CYC (`CPSR_IDLE_RESET_US * `CPSR_CLK_MHZ)
`define CPSR_PWM_STEP_CYC (`CPSR_CLK_HZ / (`CPSR_REFRESH_HZ * `CPSR_LEVELS))

// Counter widths
`define CPSR_HCNT_W 7
`define CPSR_LCNT_W 14
`define CPSR_BCNT_W 5
`define CPSR_STEP_W 7

`endif

// ==== hdl/cpsr_pkg.sv ====
package cpsr_pkg;

  // Colour word in arrival order
  typedef struct packed {
    logic [7:0] green;
    logic [7:0] red;
    logic [7:0] blue;
  } cpsr_grb_t;

  // Modulated channel drives
  typedef struct packed {
    logic green;
    logic red;
    logic blue;
  } cpsr_led_t;

  typedef enum logic {
    SRC_PRIMARY,
    SRC_STANDBY
  } cpsr_src_t;

endpackage : cpsr_pkg

// ==== hdl/cpsr_receiver.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cpsr_defines.svh"

module cpsr_receiver #(
  parameter int unsigned IDLE_RESET_CYCLES = `CPSR_IDLE_RESET_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic primary_serial_input,
  input wire logic standby_serial_input,
  output logic cascade_serial_output,
  output logic standby_selected,
  output cpsr_pkg::cpsr_led_t led_drive
);

  localparam logic [`CPSR_HCNT_W-1:0] HCNT_MAX = '1;
  localparam logic [`CPSR_BCNT_W-1:0] WORD_BITS = `CPSR_BCNT_W'(`CPSR_WORD_BITS);

  function automatic logic cpsr_is_one(input logic [`CPSR_HCNT_W-1:0] cnt);
    cpsr_is_one = (cnt >= `CPSR_HCNT_W'(`CPSR_THRESH_CYC));
  endfunction : cpsr_is_one

  // State
  cpsr_pkg::cpsr_src_t src, next_src;
  logic prim_q, next_prim_q, stby_q, next_stby_q, line_q, next_line_q;
  logic [`CPSR_BCNT_W-1:0] loss_cnt, next_loss_cnt;
  logic [`CPSR_HCNT_W-1:0] high_cnt, next_high_cnt;
  logic [`CPSR_LCNT_W-1:0] low_cnt, next_low_cnt;
  logic [`CPSR_BCNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [`CPSR_WORD_BITS-1:0] shift, next_shift;
  cpsr_pkg::cpsr_grb_t own_word, next_own_word, drive_word, next_drive_word;
  logic fwd_bit, next_fwd_bit, one_seen, next_one_seen;
  logic cascade, next_cascade;
  logic [`CPSR_STEP_W-1:0] step_cnt, next_step_cnt;
  logic [7:0] pwm_cnt, next_pwm_cnt;
  cpsr_pkg::cpsr_led_t next_led;

  logic line, rise, fall, frame_end, bit_done;

  always_comb begin
    line = (src == cpsr_pkg::SRC_STANDBY) ? standby_serial_input : primary_serial_input;
    rise = line & ~line_q;
    fall = ~line & line_q;
    frame_end = ~line && (low_cnt == `CPSR_LCNT_W'(IDLE_RESET_CYCLES - 1));
    bit_done = fall && (bit_cnt != WORD_BITS);
  end

  // Source selection
  always_comb begin
    next_prim_q = primary_serial_input;
    next_stby_q = standby_serial_input;
    next_loss_cnt = loss_cnt;
    if (primary_serial_input && !prim_q) begin
      next_loss_cnt = '0;
    end else if (standby_serial_input && !stby_q && loss_cnt != WORD_BITS) begin
      next_loss_cnt = loss_cnt + `CPSR_BCNT_W'(1);
    end
    next_src = src;
    if (loss_cnt == WORD_BITS) begin
      next_src = cpsr_pkg::SRC_STANDBY;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      src <= cpsr_pkg::SRC_PRIMARY;
      prim_q <= 1'b0;
      stby_q <= 1'b0;
      loss_cnt <= '0;
    end else begin
      src <= next_src;
      prim_q <= next_prim_q;
      stby_q <= next_stby_q;
      loss_cnt <= next_loss_cnt;
    end
  end

  // Line decoder, capture and forwarding
  always_comb begin
    next_line_q = line;
    next_high_cnt = high_cnt;
    if (rise) begin
      next_high_cnt = `CPSR_HCNT_W'(1);
    end else if (high_cnt != HCNT_MAX) begin
      next_high_cnt = high_cnt + `CPSR_HCNT_W'(1);
    end
    next_low_cnt = low_cnt;
    if (line) begin
      next_low_cnt = '0;
    end else if (low_cnt != `CPSR_LCNT_W'(IDLE_RESET_CYCLES)) begin
      next_low_cnt = low_cnt + `CPSR_LCNT_W'(1);
    end
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_own_word = own_word;
    next_drive_word = drive_word;
    if (frame_end) begin
      next_drive_word = own_word;
      next_bit_cnt = '0;
    end else if (bit_done) begin
      next_shift = {shift[`CPSR_WORD_BITS-2:0], cpsr_is_one(high_cnt)};
      next_bit_cnt = bit_cnt + `CPSR_BCNT_W'(1);
      if (bit_cnt == WORD_BITS - `CPSR_BCNT_W'(1)) begin
        next_own_word = {shift[`CPSR_WORD_BITS-2:0], cpsr_is_one(high_cnt)};
      end
    end
    next_fwd_bit = rise ? (bit_cnt == WORD_BITS) : fwd_bit;
    next_one_seen = rise ? 1'b0 : (one_seen | (line && cpsr_is_one(next_high_cnt)));
    next_cascade = next_fwd_bit && ((next_high_cnt <= `CPSR_HCNT_W'(`CPSR_ZERO_OUT_CYC))
      || (line && !cpsr_is_one(next_high_cnt))
      || (next_one_seen && next_high_cnt <= `CPSR_HCNT_W'(`CPSR_ONE_OUT_CYC)));
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      line_q <= 1'b0;
      high_cnt <= HCNT_MAX;
      low_cnt <= '0;
      shift <= '0;
      bit_cnt <= '0;
      own_word <= '0;
      drive_word <= '0;
      fwd_bit <= 1'b0;
      one_seen <= 1'b0;
      cascade <= 1'b0;
    end else begin
      line_q <= next_line_q;
      high_cnt <= next_high_cnt;
      low_cnt <= next_low_cnt;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      own_word <= next_own_word;
      drive_word <= next_drive_word;
      fwd_bit <= next_fwd_bit;
      one_seen <= next_one_seen;
      cascade <= next_cascade;
    end
  end

  // Intensity modulation
  always_comb begin
    next_step_cnt = step_cnt + `CPSR_STEP_W'(1);
    next_pwm_cnt = pwm_cnt;
    if (step_cnt == `CPSR_STEP_W'(`CPSR_PWM_STEP_CYC - 1)) begin
      next_step_cnt = '0;
      next_pwm_cnt = pwm_cnt + 8'h01;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      assign next_led[ch] = (pwm_cnt < drive_word[8*ch +: 8]);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      step_cnt <= '0;
      pwm_cnt <= '0;
      led_drive <= '0;
    end else begin
      step_cnt <= next_step_cnt;
      pwm_cnt <= next_pwm_cnt;
      led_drive <= next_led;
    end
  end

  assign cascade_serial_output = cascade;
  assign standby_selected = (src == cpsr_pkg::SRC_STANDBY);

  // Checks
  property p_switch_cause;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(standby_selected) |-> $past(loss_cnt) == WORD_BITS;
  endproperty
  a_switch_cause: assert property (p_switch_cause) else $error("source switched without loss");

  property p_primary_first;
    @(posedge clk_sys) disable iff (!resetn)
    (loss_cnt != WORD_BITS && !standby_selected) |=> !standby_selected;
  endproperty
  a_primary_first: assert property (p_primary_first) else $error("left primary too early");

  property p_standby_sticky;
    @(posedge clk_sys) disable iff (!resetn)
    standby_selected |=> standby_selected [*8];
  endproperty
  a_standby_sticky: assert property (p_standby_sticky) else $error("standby selection lost");

  property p_capture_word;
    @(posedge clk_sys) disable iff (!resetn)
    (bit_done && !frame_end && bit_cnt == WORD_BITS - `CPSR_BCNT_W'(1))
      |=> (bit_cnt == WORD_BITS) && (own_word == shift) && (own_word.green == shift[23:16]);
  endproperty
  a_capture_word: assert property (p_capture_word) else $error("word not captured");

  property p_forward_only_after;
    @(posedge clk_sys) disable iff (!resetn)
    (rise && bit_cnt != WORD_BITS) |=> !cascade_serial_output;
  endproperty
  a_forward_only_after: assert property (p_forward_only_after) else $error("own bit forwarded");

  property p_forward_shape;
    @(posedge clk_sys) disable iff (!resetn)
    (rise && bit_cnt == WORD_BITS && !frame_end) |=> cascade_serial_output [*8];
  endproperty
  a_forward_shape: assert property (p_forward_shape) else $error("forwarded bit too short");

  property p_idle_len;
    @(posedge clk_sys) disable iff (!resetn)
    frame_end |-> !line && (low_cnt == `CPSR_LCNT_W'(IDLE_RESET_CYCLES - 1));
  endproperty
  a_idle_len: assert property (p_idle_len) else $error("reset seen too soon");

  property p_frame_load;
    @(posedge clk_sys) disable iff (!resetn)
    frame_end |=> (drive_word == $past(own_word)) && (bit_cnt == '0);
  endproperty
  a_frame_load: assert property (p_frame_load) else $error("frame end not applied");

  property p_bit_value;
    @(posedge clk_sys) disable iff (!resetn)
    (bit_done && !frame_end) |=> shift[0] == ($past(high_cnt) >= `CPSR_HCNT_W'(`CPSR_THRESH_CYC));
  endproperty
  a_bit_value: assert property (p_bit_value) else $error("bit value wrong");

  property p_pwm_step;
    @(posedge clk_sys) disable iff (!resetn)
    (step_cnt == `CPSR_STEP_W'(`CPSR_PWM_STEP_CYC - 1)) |=> pwm_cnt == $past(pwm_cnt) + 8'h01;
  endproperty
  a_pwm_step: assert property (p_pwm_step) else $error("modulation step wrong");

  property p_led_level;
    @(posedge clk_sys) disable iff (!resetn)
    1'b1 |=> led_drive.green == ($past(pwm_cnt) < $past(drive_word.green));
  endproperty
  a_led_level: assert property (p_led_level) else $error("green drive wrong");

  c_switch: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(standby_selected));
  c_frame: cover property (@(posedge clk_sys) disable iff (!resetn) frame_end && own_word != '0);
  c_forward: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(cascade_serial_output));
  c_word: cover property (@(posedge clk_sys) disable iff (!resetn) bit_done && bit_cnt == WORD_BITS - 5'h01);

endmodule : cpsr_receiver
`default_nettype wire

// ==== verification/cpsr_line_driver.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpsr_line_driver (
  input wire logic clk_sys,
  output logic line
);
  initial line = 1'b0;

  task automatic hold(input logic lvl, input int n);
    line <= lvl;
    repeat (n) @(posedge clk_sys);
  endtask : hold

  // Fast bit 63 cycles, slow bit 70 cycles
  task automatic send_bit(input logic b, input logic slow);
    int hi;
    hi = slow ? 20 : 15;
    if (b) begin
      hi = slow ? 50 : 40;
    end
    hold(1'b1, hi);
    hold(1'b0, (slow ? 70 : 63) - hi);
  endtask : send_bit

  task automatic idle(input int n);
    hold(1'b0, n);
  endtask : idle
endmodule : cpsr_line_driver
`default_nettype wire

// ==== verification/test_cpsr_receiver.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t %s", $time, m); end end
module test_cpsr_receiver;
  localparam int IDLE = 200;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  wire pri_line;
  wire stb_line;
  logic cascade;
  logic standby_sel;
  cpsr_pkg::cpsr_led_t led;
  int n_errors = 0;
  int check_count = 0;
  int width = 0;
  logic fwd;
  logic exp_q[$];
  logic [23:0] w;

  cpsr_receiver #(.IDLE_RESET_CYCLES(IDLE)) DUT (.clk_sys(clk_sys), .resetn(resetn),
    .primary_serial_input(pri_line), .standby_serial_input(stb_line), .cascade_serial_output(cascade),
    .standby_selected(standby_sel), .led_drive(led));
  cpsr_line_driver pri_drv (.clk_sys(clk_sys), .line(pri_line));
  cpsr_line_driver stb_drv (.clk_sys(clk_sys), .line(stb_line));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // Decode each cascade pulse against the oldest note
  always @(posedge clk_sys) begin
    if (cascade === 1'b1) begin
      width <= width + 1;
    end else if (width != 0) begin
      fwd = (width >= 30);
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0, "unexpected cascade pulse")
      else `CHK(fwd, exp_q.pop_front(), "forwarded bit value")
      if (fwd) `CHK(width, 45, "one pulse width")
      else `CHK(width >= 15, 1'b1, "zero pulse width")
      width <= 0;
    end
  end

  task automatic put_bit(input logic b, input logic slow, input logic stb);
    if (stb) stb_drv.send_bit(b, slow);
    else pri_drv.send_bit(b, slow);
  endtask : put_bit

  task automatic put_idle(input int n, input logic stb);
    if (stb) stb_drv.idle(n);
    else pri_drv.idle(n);
  endtask : put_idle

  task automatic frame(input logic [23:0] v, input int nfwd, input logic slow, input logic stb, input int gap);
    logic b;
    for (int i = 23; i >= 0; i--) begin
      if (i == 11 && gap > 0) put_idle(gap, stb);
      put_bit(v[i], slow, stb);
    end
    for (int i = 0; i < nfwd; i++) begin
      b = 1'($urandom);
      exp_q.push_back(b);
      put_bit(b, slow, stb);
    end
    put_idle(IDLE + 20, stb);
  endtask : frame

  // One full modulation period gives level times 97 high cycles
  task automatic led_check(input logic [23:0] v);
    int g;
    int r;
    int b;
    g = 0;
    r = 0;
    b = 0;
    repeat (24832) begin
      @(posedge clk_sys);
      g += int'(led.green === 1'b1);
      r += int'(led.red === 1'b1);
      b += int'(led.blue === 1'b1);
    end
    `CHK(g, int'(v[23:16]) * 97, "green duty")
    `CHK(r, int'(v[15:8]) * 97, "red duty")
    `CHK(b, int'(v[7:0]) * 97, "blue duty")
  endtask : led_check

  task automatic complete_run;
    `CHK(exp_q.size(), 0, "forwarded bits missing")
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end

  initial begin
    void'($urandom(38));
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK(standby_sel, 1'b0, "standby after reset")
    frame(24'hff_0001, 3, 1'b0, 1'b0, 0);
    led_check(24'hff_0001);
    w = 24'($urandom);
    frame(w, 3, 1'b1, 1'b0, IDLE / 2);
    led_check(w);
    for (int i = 0; i < 24; i++) put_bit(1'($urandom), 1'b0, 1'b1);
    for (int i = 0; i < 200 && standby_sel !== 1'b1; i++) @(posedge clk_sys);
    `CHK(standby_sel, 1'b1, "switch to standby")
    put_idle(IDLE + 20, 1'b1);
    w = 24'($urandom);
    frame(w, 2, 1'b0, 1'b1, 0);
    led_check(w);
    pri_drv.send_bit(1'b1, 1'b0);
    pri_drv.idle(IDLE + 20);
    `CHK(standby_sel, 1'b1, "standby kept")
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(standby_sel, 1'b0, "primary after restart")
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    frame(24'($urandom), 1, 1'b0, 1'b0, 0);
    `CHK(standby_sel, 1'b0, "primary kept after restart")
    complete_run();
  end
endmodule : test_cpsr_receiver
`default_nettype wire
